/* File: design/smm_regs.vh */
`ifndef SMM_REGS_VH
`define SMM_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SMM_OFS_CFG      8'h00
`define SMM_OFS_CTRL     8'h04
`define SMM_OFS_STAT     8'h08
`define SMM_OFS_TT       8'h0C
`define SMM_OFS_ISQP     8'h10
`define SMM_ISQ_BASE_BIT 8

// ----------------------------------------
// configuration register fields
// ----------------------------------------
`define SMM_CFG_EN       0
`define SMM_CFG_AREA_B   1
`define SMM_CFG_CSZ_LO   2
`define SMM_CFG_DSZ_LO   4
`define SMM_CFG_TTR_LO   7
`define SMM_CFG_TT_SW    10
`define SMM_CFG_SYN_CLR  11
`define SMM_CFG_SYN_LD   12
`define SMM_CFG_SYN_LSB  13
`define SMM_CFG_Q_VALID  14
`define SMM_CFG_Q_INVAL  15
`define SMM_CFG_RESET    16'h0000
`define SMM_CTRL_TT_STEP 0
`define SMM_STAT_TT_ROLL 0
`define SMM_STAT_BUSY    1

// ----------------------------------------
// fixed shared-ram locations
// ----------------------------------------
`define SMM_CSP_A        16'h0102
`define SMM_DSP_A        16'h0103
`define SMM_CSP_B        16'h0106
`define SMM_DSP_B        16'h0107
`define SMM_LUT_BASE     16'h0280
`define SMM_LUT_LAST     16'h02FF

// ----------------------------------------
// stack sizes and timing
// ----------------------------------------
`define SMM_CS_MIN       17'h00100
`define SMM_DS_MIN       17'h00200
`define SMM_DESC_WORDS   17'h00004
`define SMM_ISQ_DEPTH    64
`define SMM_CLK_MHZ      50
`define SMM_TT_BASE_US   2
`define SMM_TT_BASE_CYC  (`SMM_TT_BASE_US * `SMM_CLK_MHZ)

`endif

/* File: design/smm_monitor.v */
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Functional notes
// - command stack pointer lives at word 102h (area A) or 106h (area B)
// - data stack pointer lives at word 103h (area A) or 107h (area B)
// - lookup table occupies words 0280h..02FFh, 128 enable words
// - no monitor fixed location overlaps any terminal fixed location
// - lookup read after each command; clear bit ignores whole message
// - descriptor at command pointer, message words sequentially from data pointer
// - receive message: command in descriptor, data then status in data stack
// - command stack 256/1K/4K/16K words; advance and wrap follow size
// - data stack 512 to 64K words; data pointer wrap follows size
// - events for end of message, stack 50% and 100% rollover
// - 50% event when pointer enters second half of stack
// - chronological status queue, filtered on valid and/or invalid messages
// - queue holds 64 words, two per entry, 32 messages then wraps
// - 16-bit host read/write time tag, 2 to 64 us per count
// - software option steps the time tag instead of the timebase
// - time tag value stored in second descriptor word
// - time tag wrap FFFF to 0000 sets status bit and event
// - sync without data clears, sync with data loads the time tag
// - optional filter loads sync data only when its lsb is zero
// - current time tag offered as sync-with-data word for controller
// - engine may load time tag immediate and copy it to general queue
// - lookup address 280h + rt address, t/r, sa4; sa3..0 selects bit
// - second command of terminal-to-terminal transfer goes to data stack
`include "smm_regs.vh"

module smm_monitor #(
  parameter TT_BASE_CYC = `SMM_TT_BASE_CYC
) (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // decoded 1553 words
  input  wire        cmd_valid_i,
  input  wire [15:0] cmd_word_i,
  input  wire        word_valid_i,
  input  wire [15:0] word_i,
  input  wire        eom_i,
  input  wire        eom_err_i,
  // shared ram master port
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg  [15:0] mem_addr_o,
  output reg  [15:0] mem_wdata_o,
  input  wire        mem_ack_i,
  input  wire [15:0] mem_rdata_i,
  // events, one-cycle pulses
  output reg         ev_eom_o,
  output reg         ev_cs50_o,
  output reg         ev_cs100_o,
  output reg         ev_ds50_o,
  output reg         ev_ds100_o,
  output reg         ev_tt_roll_o,
  // time tag side ports
  input  wire        sync_clr_i,
  input  wire        sync_load_i,
  input  wire [15:0] sync_data_i,
  input  wire        tt_load_i,
  input  wire [15:0] tt_load_data_i,
  input  wire        tt_gpq_i,
  output wire [15:0] tt_value_o,
  output reg         gpq_valid_o,
  output reg  [15:0] gpq_data_o
);

  localparam S_IDLE = 3'h0;
  localparam S_LUT  = 3'h1;
  localparam S_CPR  = 3'h2;
  localparam S_DPR  = 3'h3;
  localparam S_MSG  = 3'h4;
  localparam S_DWR  = 3'h5;
  localparam S_DESC = 3'h6;
  localparam S_PTR  = 3'h7;

  reg  [15:0] cfg;
  reg         tt_roll_st;
  reg  [15:0] tt;
  reg  [15:0] isq [0:`SMM_ISQ_DEPTH-1];
  reg  [5:0]  isq_wp;
  reg  [2:0]  state;
  reg  [1:0]  idx;
  reg  [15:0] cmd_hold;
  reg  [15:0] tt_snap;
  reg  [15:0] cp;
  reg  [15:0] dp;
  reg  [15:0] dp_start;
  reg  [15:0] wcnt;
  reg         word_pend;
  reg  [15:0] word_hold;
  reg         eom_pend;
  reg         err_hold;
  reg         ap_wr;
  reg         ap_rd;
  reg  [7:0]  ap_ofs;
  reg  [8:0]  ap_hi;
  reg  [31:0] rdata;
  reg  [15:0] pre_cnt;
  reg  [5:0]  res_cnt;
  reg  [15:0] next_tt;
  reg         tt_inc;

  wire        area_b  = cfg[`SMM_CFG_AREA_B];
  wire [15:0] csp_loc = area_b ? `SMM_CSP_B : `SMM_CSP_A;
  wire [15:0] dsp_loc = area_b ? `SMM_DSP_B : `SMM_DSP_A;
  wire [1:0]  csz     = cfg[`SMM_CFG_CSZ_LO+1:`SMM_CFG_CSZ_LO];
  wire [2:0]  dsz     = cfg[`SMM_CFG_DSZ_LO+2:`SMM_CFG_DSZ_LO];
  wire [2:0]  ttr     = cfg[`SMM_CFG_TTR_LO+2:`SMM_CFG_TTR_LO];

  // ----------------------------------------
  // stack geometry
  // ----------------------------------------
  // sizes are powers of two, so wrap is a masked add
  wire [16:0] cs_len  = `SMM_CS_MIN << {csz, 1'b0};
  wire [16:0] ds_len  = `SMM_DS_MIN << dsz;
  wire [16:0] cs_mask = cs_len - 17'h00001;
  wire [16:0] ds_mask = ds_len - 17'h00001;
  wire [16:0] cs_half = {1'b0, cs_len[16:1]};
  wire [16:0] ds_half = {1'b0, ds_len[16:1]};
  wire [16:0] cp_sum  = {1'b0, cp} + `SMM_DESC_WORDS;
  wire [16:0] dp_sum  = {1'b0, dp} + 17'h00001;
  wire [16:0] cp_off  = cp_sum & cs_mask;
  wire [16:0] dp_off  = dp_sum & ds_mask;
  wire [16:0] cp_nx17 = ({1'b0, cp} & ~cs_mask) | cp_off;
  wire [16:0] dp_nx17 = ({1'b0, dp} & ~ds_mask) | dp_off;
  wire [15:0] cp_next = cp_nx17[15:0];
  wire [15:0] dp_next = dp_nx17[15:0];

  // lookup address: 280h base, then rt address, t/r, sa4
  wire [4:0]  terminal_address_bits = cmd_hold[15:11];
  wire [15:0] lut_addr = `SMM_LUT_BASE |
                         {9'h000, terminal_address_bits, cmd_hold[10], cmd_hold[9]};
  wire [3:0]  lut_bit  = cmd_hold[8:5];

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  wire ap_valid = hsel_i & htrans_i[1] & hready_i;

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata;
  assign tt_value_o  = tt;

  // address phase capture; reads answer in the data phase from a flop
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ap_wr  <= 1'b0;
      ap_rd  <= 1'b0;
      ap_ofs <= 8'h00;
      ap_hi  <= 9'h000;
      rdata  <= 32'h00000000;
    end else begin
      ap_wr  <= ap_valid & hwrite_i;
      ap_rd  <= ap_valid & ~hwrite_i;
      ap_ofs <= haddr_i[7:0];
      ap_hi  <= haddr_i[16:8];
      rdata  <= 32'h00000000;
      if (ap_valid & ~hwrite_i) begin
        if (haddr_i[16:8] == 9'h001)
          rdata <= {16'h0000, isq[haddr_i[7:2]]};
        else if (haddr_i[16:8] == 9'h000) begin
          case (haddr_i[7:0])
            `SMM_OFS_CFG:  rdata <= {16'h0000, cfg};
            `SMM_OFS_STAT: rdata <= {30'h00000000, state != S_IDLE, tt_roll_st};
            `SMM_OFS_TT:   rdata <= {16'h0000, tt};
            `SMM_OFS_ISQP: rdata <= {26'h0000000, isq_wp};
            default:       rdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  wire wr_top  = ap_wr & (ap_hi == 9'h000);
  wire wr_cfg  = wr_top & (ap_ofs == `SMM_OFS_CFG);
  wire wr_ctrl = wr_top & (ap_ofs == `SMM_OFS_CTRL);
  wire wr_stat = wr_top & (ap_ofs == `SMM_OFS_STAT);
  wire wr_tt   = wr_top & (ap_ofs == `SMM_OFS_TT);

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      cfg <= `SMM_CFG_RESET;
    else if (wr_cfg)
      cfg <= hwdata_i[15:0];
  end

  // ----------------------------------------
  // time tag timebase
  // ----------------------------------------
  // 2 us base tick, then 2^ttr ticks per count; codes above 5 act as 64 us
  wire base_tick = (pre_cnt == TT_BASE_CYC - 1);
  wire [5:0] res_last = (ttr > 3'h5) ? 6'h1F : ((6'h01 << ttr) - 6'h01);

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_cnt <= 16'h0000;
      res_cnt <= 6'h00;
    end else if (base_tick) begin
      pre_cnt <= 16'h0000;
      res_cnt <= (res_cnt >= res_last) ? 6'h00 : res_cnt + 6'h01;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  // increment source: timebase or software step
  always @* begin
    if (cfg[`SMM_CFG_TT_SW])
      tt_inc = wr_ctrl & hwdata_i[`SMM_CTRL_TT_STEP];
    else
      tt_inc = base_tick & (res_cnt >= res_last);
  end

  // load sources in priority order: host, engine, sync clear, sync load
  always @* begin
    next_tt = tt;
    if (wr_tt)
      next_tt = hwdata_i[15:0];
    else if (tt_load_i)
      next_tt = tt_load_data_i;
    else if (sync_clr_i & cfg[`SMM_CFG_SYN_CLR])
      next_tt = 16'h0000;
    else if (sync_load_i & cfg[`SMM_CFG_SYN_LD] &
             ~(cfg[`SMM_CFG_SYN_LSB] & sync_data_i[0]))
      next_tt = sync_data_i;
    else if (tt_inc)
      next_tt = tt + 16'h0001;
  end

  wire tt_wrap = tt_inc & (tt == 16'hFFFF) & ~wr_tt & ~tt_load_i &
                 ~(sync_clr_i & cfg[`SMM_CFG_SYN_CLR]) & (next_tt == 16'h0000);

  // rollover sticky: a new wrap wins over a write-one clear
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tt           <= 16'h0000;
      tt_roll_st   <= 1'b0;
      ev_tt_roll_o <= 1'b0;
      gpq_valid_o  <= 1'b0;
      gpq_data_o   <= 16'h0000;
    end else begin
      tt           <= next_tt;
      ev_tt_roll_o <= tt_wrap;
      if (tt_wrap)
        tt_roll_st <= 1'b1;
      else if (wr_stat & hwdata_i[`SMM_STAT_TT_ROLL])
        tt_roll_st <= 1'b0;
      gpq_valid_o <= tt_gpq_i;
      if (tt_gpq_i)
        gpq_data_o <= tt;
    end
  end

  // ----------------------------------------
  // message sequencer
  // ----------------------------------------
  // one word is held while memory is busy; bus words arrive 20 us apart
  wire mem_done = mem_req_o & mem_ack_i;
  wire log_it   = err_hold ? cfg[`SMM_CFG_Q_INVAL] : cfg[`SMM_CFG_Q_VALID];

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state       <= S_IDLE;
      idx         <= 2'h0;
      cmd_hold    <= 16'h0000;
      tt_snap     <= 16'h0000;
      cp          <= 16'h0000;
      dp          <= 16'h0000;
      dp_start    <= 16'h0000;
      wcnt        <= 16'h0000;
      word_pend   <= 1'b0;
      word_hold   <= 16'h0000;
      eom_pend    <= 1'b0;
      err_hold    <= 1'b0;
      isq_wp      <= 6'h00;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 16'h0000;
      ev_eom_o    <= 1'b0;
      ev_cs50_o   <= 1'b0;
      ev_cs100_o  <= 1'b0;
      ev_ds50_o   <= 1'b0;
      ev_ds100_o  <= 1'b0;
    end else begin
      ev_eom_o   <= 1'b0;
      ev_cs50_o  <= 1'b0;
      ev_cs100_o <= 1'b0;
      ev_ds50_o  <= 1'b0;
      ev_ds100_o <= 1'b0;
      // words and end marks are latched in any active state
      if (state != S_IDLE) begin
        if (word_valid_i) begin
          word_pend <= 1'b1;
          word_hold <= word_i;
        end
        if (eom_i) begin
          eom_pend <= 1'b1;
          err_hold <= eom_err_i;
        end
      end
      if (mem_done)
        mem_req_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_valid_i & cfg[`SMM_CFG_EN]) begin
            cmd_hold  <= cmd_word_i;
            tt_snap   <= tt;
            word_pend <= 1'b0;
            eom_pend  <= 1'b0;
            err_hold  <= 1'b0;
            wcnt      <= 16'h0000;
            state     <= S_LUT;
          end
        end
        S_LUT: begin
          if (!mem_req_o) begin
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b0;
            mem_addr_o <= lut_addr;
          end else if (mem_ack_i) begin
            state <= mem_rdata_i[lut_bit] ? S_CPR : S_IDLE;
          end
        end
        S_CPR: begin
          if (!mem_req_o) begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= csp_loc;
          end else if (mem_ack_i) begin
            cp    <= mem_rdata_i;
            state <= S_DPR;
          end
        end
        S_DPR: begin
          if (!mem_req_o) begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= dsp_loc;
          end else if (mem_ack_i) begin
            dp       <= mem_rdata_i;
            dp_start <= mem_rdata_i;
            state    <= S_MSG;
          end
        end
        S_MSG: begin
          // data, status and a second command all stream in bus order
          if (word_pend)
            state <= S_DWR;
          else if (eom_pend) begin
            idx   <= 2'h0;
            state <= S_DESC;
          end
        end
        S_DWR: begin
          if (!mem_req_o) begin
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b1;
            mem_addr_o  <= dp;
            mem_wdata_o <= word_hold;
            word_pend   <= word_valid_i;
          end else if (mem_ack_i) begin
            dp         <= dp_next;
            wcnt       <= wcnt + 16'h0001;
            ev_ds50_o  <= (dp_off == ds_half);
            ev_ds100_o <= (dp_off == 17'h00000);
            mem_we_o   <= 1'b0;
            state      <= S_MSG;
          end
        end
        S_DESC: begin
          if (!mem_req_o) begin
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b1;
            mem_addr_o <= cp | {14'h0000, idx};
            case (idx)
              2'h0:    mem_wdata_o <= {err_hold, wcnt[14:0]};
              2'h1:    mem_wdata_o <= tt_snap;
              2'h2:    mem_wdata_o <= dp_start;
              default: mem_wdata_o <= cmd_hold;
            endcase
          end else if (mem_ack_i) begin
            idx <= idx + 2'h1;
            if (idx == 2'h3) begin
              cp         <= cp_next;
              ev_cs50_o  <= (cp_off == cs_half);
              ev_cs100_o <= (cp_off == 17'h00000);
              idx        <= 2'h0;
              state      <= S_PTR;
            end
          end
        end
        S_PTR: begin
          if (!mem_req_o) begin
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b1;
            mem_addr_o  <= idx[0] ? dsp_loc : csp_loc;
            mem_wdata_o <= idx[0] ? dp : cp;
          end else if (mem_ack_i) begin
            idx <= 2'h1;
            if (idx[0]) begin
              mem_we_o <= 1'b0;
              ev_eom_o <= 1'b1;
              if (log_it)
                isq_wp <= isq_wp + 6'h02;
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // interrupt status queue, two words per entry
  // ----------------------------------------
  // entry: {eom, error, data word count} then next descriptor address
  wire isq_push = (state == S_PTR) & mem_done & idx[0] & log_it;
  genvar gi;
  generate
    for (gi = 0; gi < `SMM_ISQ_DEPTH; gi = gi + 1) begin : g_isq
      always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
          isq[gi] <= 16'h0000;
        else if (isq_push & (isq_wp == gi))
          isq[gi] <= {1'b1, err_hold, wcnt[13:0]};
        else if (isq_push & (isq_wp + 6'h01 == gi))
          isq[gi] <= cp;
      end
    end
  endgenerate

endmodule

/* File: dv/smm_monitor_asserts.sv */
`timescale 1ns/1ps
`include "smm_regs.vh"
module smm_monitor_chk (
  input wire        core_clk_i,
  input wire        rst_b_i,
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire        mem_req_o,
  input wire        mem_we_o,
  input wire [15:0] mem_addr_o,
  input wire [15:0] mem_wdata_o,
  input wire        mem_ack_i,
  input wire        ev_tt_roll_o,
  input wire        tt_load_i,
  input wire [15:0] tt_load_data_i,
  input wire        tt_gpq_i,
  input wire [15:0] tt_value_o,
  input wire        gpq_valid_o,
  input wire [15:0] gpq_data_o
);
  logic rd_dp;
  logic tt_wr;
  // ----------------------------------------
  // data phase tracking
  // ----------------------------------------
  // host write to the time tag outranks an engine load
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_dp <= 1'b0;
      tt_wr <= 1'b0;
    end else begin
      rd_dp <= hsel_i && htrans_i[1] && hready_i && !hwrite_i;
      tt_wr <= hsel_i && htrans_i[1] && hready_i && hwrite_i && haddr_i[16:0] == 17'h0000C;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  ahb_always_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus response not ready or not okay");
  rdata_idle_a: assert property (!rd_dp |-> hrdata_o == 32'h0)
    else $error("read data outside read data phase");
  mem_hold_a: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
    else $error("ram request changed before ack");
  ack_ends_a: assert property (mem_ack_i |=> !mem_req_o)
    else $error("ram request kept after ack");
  lut_no_write_a: assert property (mem_req_o && mem_we_o |-> mem_addr_o[15:7] != 9'h005)
    else $error("write into lookup table");
  gpq_capture_a: assert property (tt_gpq_i |=>
    gpq_valid_o && gpq_data_o == $past(tt_value_o))
    else $error("queue copy of time tag wrong");
  tt_load_a: assert property (tt_load_i && !tt_wr |=> tt_value_o == $past(tt_load_data_i))
    else $error("time tag immediate load lost");
  roll_zero_a: assert property (ev_tt_roll_o |-> tt_value_o == 16'h0000)
    else $error("rollover event without wrap");
  cover property (ev_tt_roll_o);
  cover property (gpq_valid_o);
  cover property (mem_req_o && mem_we_o && mem_ack_i);
endmodule
bind smm_monitor smm_monitor_chk i_smm_monitor_chk (
  .core_clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i,
  .ev_tt_roll_o, .tt_load_i, .tt_load_data_i, .tt_gpq_i, .tt_value_o, .gpq_valid_o,
  .gpq_data_o);

/* File: dv/smm_ram_model.sv */
`timescale 1ns/1ps
module smm_ram_model (
  input  wire         core_clk_i,
  input  wire         rst_b_i,
  input  wire         req_i,
  input  wire         we_i,
  input  wire  [15:0] addr_i,
  input  wire  [15:0] wdata_i,
  input  wire         slow_i,
  output logic        ack_o,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:65535];
  int          wr_count = 0;
  int          waits;
  // ----------------------------------------
  // shared ram
  // ----------------------------------------
  // cleared so an untouched lookup word reads as disabled
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // ack after 0 or 3 waits; idle read bus toggles so stale data never matches
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 16'h5A5A;
      waits   <= 0;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        if (waits < (slow_i ? 3 : 0)) begin
          waits <= waits + 1;
        end else begin
          waits <= 0;
          ack_o <= 1'b1;
          if (we_i) begin
            mem[addr_i] <= wdata_i;
            wr_count    <= wr_count + 1;
          end else begin
            rdata_o <= mem[addr_i];
          end
        end
      end
    end
  end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
`include "smm_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
  logic        core_clk_i = 0, rst_b_i = 0, hsel_i = 0, hwrite_i = 0, slow = 0;
  logic        cmd_valid_i = 0, word_valid_i = 0, eom_i = 0, eom_err_i = 0;
  logic        sync_clr_i = 0, sync_load_i = 0, tt_load_i = 0, tt_gpq_i = 0;
  logic [1:0]  htrans_i = 0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd, lf = 32'h60F9D55A;
  logic [15:0] cmd_word_i = 0, word_i = 0, sync_data_i = 0, tt_load_data_i = 0;
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, tt_value_o, gpq_data_o;
  logic        hreadyout_o, hresp_o, mem_req_o, mem_we_o, mem_ack_i, gpq_valid_o;
  logic        ev_eom_o, ev_cs50_o, ev_cs100_o, ev_ds50_o, ev_ds100_o, ev_tt_roll_o;
  logic [15:0] wq [4];
  int          fail_count = 0, tests_run = 0, evc [6], w0;
  wire         hready_i = hreadyout_o;
  smm_monitor #(.TT_BASE_CYC(5)) i_smm_monitor (
    .core_clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .cmd_valid_i, .cmd_word_i, .word_valid_i,
    .word_i, .eom_i, .eom_err_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i,
    .mem_rdata_i, .ev_eom_o, .ev_cs50_o, .ev_cs100_o, .ev_ds50_o, .ev_ds100_o, .ev_tt_roll_o,
    .sync_clr_i, .sync_load_i, .sync_data_i, .tt_load_i, .tt_load_data_i, .tt_gpq_i,
    .tt_value_o, .gpq_valid_o, .gpq_data_o);
  smm_ram_model i_smm_ram_model (.core_clk_i, .rst_b_i, .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .slow_i(slow), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i));
  // ----------------------------------------
  // clock, event tally, helpers
  // ----------------------------------------
  always #10 core_clk_i = ~core_clk_i;
  // event pulses tallied per kind
  always @(posedge core_clk_i) begin
    evc[0] <= evc[0] + ev_eom_o;
    evc[1] <= evc[1] + ev_cs50_o;
    evc[2] <= evc[2] + ev_cs100_o;
    evc[3] <= evc[3] + ev_ds50_o;
    evc[4] <= evc[4] + ev_ds100_o;
    evc[5] <= evc[5] + ev_tt_roll_o;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // pointer step that stays inside the aligned stack
  function automatic logic [15:0] nxt(input logic [15:0] p, m, s);
    return (p & ~m) | ((p + s) & m);
  endfunction
  function automatic logic [15:0] m(input logic [15:0] a);
    return i_smm_ram_model.mem[a];
  endfunction
  task automatic ahb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {20'h0, a};
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {16'h0, d};
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [15:0] e, input string n);
    ahb(1'b0, a, 16'h0);
    `CHK(n, {16'h0, e}, rd)
  endtask
  // one-cycle strobe: 0 sync clear, 1 sync load, 2 engine load, 3 queue copy
  task automatic side(input int k, input logic [15:0] d);
    @(posedge core_clk_i);
    sync_data_i <= d;
    tt_load_data_i <= d;
    sync_clr_i <= (k == 0);
    sync_load_i <= (k == 1);
    tt_load_i <= (k == 2);
    tt_gpq_i <= (k == 3);
    @(posedge core_clk_i);
    {sync_clr_i, sync_load_i, tt_load_i, tt_gpq_i} <= 4'h0;
  endtask
  // words spaced well apart; waits on the busy flag, not a fixed delay
  task automatic msg(input logic [15:0] cw, input int n, input logic err);
    w0 = i_smm_ram_model.wr_count;
    @(posedge core_clk_i);
    cmd_word_i <= cw;
    cmd_valid_i <= 1'b1;
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (30) @(posedge core_clk_i);
      word_i <= wq[i % 4];
      word_valid_i <= (i < n);
      eom_i <= (i == n);
      eom_err_i <= err;
      @(posedge core_clk_i);
      word_valid_i <= 1'b0;
      eom_i <= 1'b0;
    end
    do ahb(1'b0, `SMM_OFS_STAT, 16'h0); while (rd[1] !== 1'b0);
  endtask
  task automatic check_msg(input logic [15:0] fx, c0, d0, cw, d0w, input int n);
    logic [15:0] d;
    d = d0;
    for (int i = 0; i < n; i++) begin
      `CHK("data word", wq[i], m(d))
      d = nxt(d, 16'h01FF, 16'h1);
    end
    `CHK("desc count", d0w, m(c0))
    `CHK("desc ttag", 16'h1234, m(c0 + 16'h1))
    `CHK("desc start", d0, m(c0 + 16'h2))
    `CHK("desc cmd", cw, m(c0 + 16'h3))
    `CHK("cmd ptr", nxt(c0, 16'h00FF, 16'h4), m(fx))
    `CHK("data ptr", d, m(fx + 16'h1))
    `CHK("writes", n + 6, i_smm_ram_model.wr_count - w0)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400us;
    fail_count++;
    wrap_up();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    chk_rd(`SMM_OFS_CFG, 16'h0000, "cfg rst");
    chk_rd(`SMM_OFS_TT, 16'h0000, "tt rst");
    chk_rd(`SMM_OFS_ISQP, 16'h0000, "isqp rst");
    ahb(1'b1, 12'h040, 16'hFFFF);
    chk_rd(12'h040, 16'h0000, "unmapped");
    ahb(1'b1, `SMM_OFS_CFG, 16'h0400);
    ahb(1'b1, `SMM_OFS_TT, 16'hFFFE);
    repeat (2) ahb(1'b1, `SMM_OFS_CTRL, 16'h0001);
    chk_rd(`SMM_OFS_TT, 16'h0000, "tt step");
    chk_rd(`SMM_OFS_STAT, 16'h0001, "roll bit");
    `CHK("roll ev", 1, evc[5])
    ahb(1'b1, `SMM_OFS_STAT, 16'h0001);
    chk_rd(`SMM_OFS_STAT, 16'h0000, "roll clr");
    lf = lfsr(lf);
    side(2, lf[15:0]);
    chk_rd(`SMM_OFS_TT, lf[15:0], "tt load");
    side(3, 16'h0);
    #1 `CHK("gpq", {1'b1, lf[15:0]}, {gpq_valid_o, gpq_data_o})
    ahb(1'b1, `SMM_OFS_CFG, 16'h0C00);
    side(0, 16'h0);
    chk_rd(`SMM_OFS_TT, 16'h0000, "sync clr");
    ahb(1'b1, `SMM_OFS_CFG, 16'h3400);
    side(1, lf[15:0] | 16'h1);
    chk_rd(`SMM_OFS_TT, 16'h0000, "sync odd");
    side(1, lf[31:16] & 16'hFFFE);
    chk_rd(`SMM_OFS_TT, lf[31:16] & 16'hFFFE, "sync even");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      wq[i] = lf[15:0];
    end
    ahb(1'b1, `SMM_OFS_TT, 16'h1234);
    ahb(1'b1, `SMM_OFS_CFG, 16'h8401);
    i_smm_ram_model.mem[16'h0294] = 16'h0008;
    i_smm_ram_model.mem[16'h02A7] = 16'h0400;
    {i_smm_ram_model.mem[16'h0102], i_smm_ram_model.mem[16'h0103]} = {16'h04FC, 16'h11FE};
    {i_smm_ram_model.mem[16'h0106], i_smm_ram_model.mem[16'h0107]} = {16'h057C, 16'h10FF};
    msg(16'h2884, 4, 1'b0);
    `CHK("off bit", 0, i_smm_ram_model.wr_count - w0)
    msg(16'h2A64, 4, 1'b0);
    `CHK("off word", 0, i_smm_ram_model.wr_count - w0)
    msg(16'h2864, 4, 1'b0);
    check_msg(`SMM_CSP_A, 16'h04FC, 16'h11FE, 16'h2864, 16'h0004, 4);
    `CHK("ev a", {32'd1, 32'd0, 32'd1, 32'd1}, {evc[0], evc[1], evc[2], evc[4]})
    slow <= 1'b1;
    ahb(1'b1, `SMM_OFS_CFG, 16'h8403);
    msg(16'h4F42, 2, 1'b1);
    check_msg(`SMM_CSP_B, 16'h057C, 16'h10FF, 16'h4F42, 16'h8002, 2);
    `CHK("ev b", {32'd2, 32'd1, 32'd1}, {evc[0], evc[1], evc[3]})
    chk_rd(`SMM_OFS_ISQP, 16'h0002, "isq index");
    chk_rd(12'h100, 16'hC002, "isq w0");
    chk_rd(12'h104, 16'h0580, "isq w1");
    for (int n = 0; n < 6; n++) begin
      ahb(1'b1, `SMM_OFS_CFG, 16'(n << 7));
      ahb(1'b1, `SMM_OFS_TT, 16'h0000);
      repeat (40 << n) @(posedge core_clk_i);
      ahb(1'b0, `SMM_OFS_TT, 16'h0000);
      `CHK("tt rate", 1'b1, (rd[15:0] >= 16'h7 && rd[15:0] <= 16'h9))
    end
    wrap_up();
  end
endmodule
